// file: nvsram_spi_pkg.sv
// Purpose: Shared constants, types and helpers for the serial nonvolatile SRAM engine.
// Assumes: 64K x 8 array, one status byte, opcodes listed below.
// Notes:   Times are in ns; cycle counts derive from the 250 MHz system clock.
`default_nettype none
package nvsram_spi_pkg;
  // Array geometry.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Command opcodes.
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ     = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
  localparam logic [7:0] OP_READ            = 8'h03;
  localparam logic [7:0] OP_WRITE           = 8'h02;
  localparam logic [7:0] OP_SAVE            = 8'h3c;
  localparam logic [7:0] OP_RESTORE         = 8'h60;
  localparam logic [7:0] OP_AUTOSAVE_ON     = 8'h59;
  localparam logic [7:0] OP_AUTOSAVE_OFF    = 8'h19;
  // Frame positions in serial clock edges.
  localparam logic [4:0] OPCODE_LAST = 5'd7;
  localparam logic [4:0] STATUS_LAST = 5'd15;
  localparam logic [4:0] ADDR_LAST   = 5'd23;
  localparam logic [4:0] DATA_PHASE  = 5'd24;
  localparam logic [2:0] BYTE_LAST   = 3'd7;
  // Status byte reset value.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Timing.
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int SAVE_TIME_NS    = 8000;
  localparam int RESTORE_TIME_NS = 200;
  localparam int SEQ_TIME_NS     = 100;
  localparam int SAVE_CYCLES_DEF    = (SAVE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESTORE_CYCLES_DEF = (RESTORE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEQ_CYCLES_DEF     = (SEQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [15:0] TIMER_IDLE = 16'h0000;

  typedef enum logic [2:0] {
    MODE_IDLE      = 3'b000,
    MODE_READ      = 3'b001,
    MODE_WRITE     = 3'b010,
    MODE_STATUS_RD = 3'b011,
    MODE_STATUS_WR = 3'b100,
    MODE_OTHER     = 3'b101
  } mode_t;

  typedef enum logic [1:0] {
    JOB_NONE    = 2'b00,
    JOB_SAVE    = 2'b01,
    JOB_RESTORE = 2'b10,
    JOB_SEQ     = 2'b11
  } job_t;

  typedef struct packed {
    logic       pin_protect_enable_bit;
    logic [2:0] spare;
    logic       block_protect_high_bit;
    logic       block_protect_low_bit;
    logic       write_latch;
    logic       busy;
  } status_t;

  // What the serial side reports about the frame just ended.
  typedef struct packed {
    mode_t      mode;
    logic [7:0] op;
    logic       st_got;
    logic [7:0] st_byte;
  } link_report_t;

  // True when the address lies in the block-protected region.
  function automatic logic in_protected(input logic [15:0] a, input logic [1:0] bp);
    case (bp)
      2'b00:   return 1'b0;
      2'b01:   return a[15:14] == 2'b11;
      2'b10:   return a[15];
      default: return 1'b1;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: nvsram_spi_engine.sv
// Purpose: Serial command engine of a 64K x 8 nonvolatile SRAM with write protection.
// Assumes: Host uses serial modes 0 or 3; cs_n high time covers at least six clk cycles.
// Notes:   Link logic runs on sck; latch, status and busy timing run on clk.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Protect pin low with pin-enable bit set blocks every status write.
// - Pin-enable bit clear makes the protect pin level irrelevant.
// - Protect pin level is taken at frame start; later changes do nothing.
// - Latch clear protects all; latch set allows unprotected blocks and status.
// - Memory read and write are refused while save or restore runs.
// - A running save shows in the status busy bit and on the busy pin.
// - Read data leaves on falling clock edges, top bit first.
// - Serial input is ignored after the read address.
// - Held select continues reading at next address, wrapping to zero.
// - Held select stores further bytes at next addresses, wrapping to zero.
// - Completed write sequence clears the write latch.
// - Burst addresses advance through protected blocks without storing there.
// - Decode save, restore and autosave-enable single byte commands.
// - Decode autosave-disable; autosave is on by default where present.
// - Save always runs fully, written or not.
// - Special commands need the latch; select rise clears it.
// - Autosave setting is volatile only.
// - Without autosave, its commands change nothing but still report busy.
// - Paused device keeps state, ignores input and floats its output.
// - Write-type commands without the latch are ignored until next frame.
// - Block bits 00 none, 01 top quarter, 10 top half, 11 all.
// - Status bit 0 reads one during save or restore.
module nvsram_spi_engine #(
  parameter bit          HAS_AUTOSAVE   = 1'b1,
  parameter logic [15:0] SAVE_CYCLES    = 16'(nvsram_spi_pkg::SAVE_CYCLES_DEF),
  parameter logic [15:0] RESTORE_CYCLES = 16'(nvsram_spi_pkg::RESTORE_CYCLES_DEF),
  parameter logic [15:0] SEQ_CYCLES     = 16'(nvsram_spi_pkg::SEQ_CYCLES_DEF)
) (
  // System clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // Serial link
  input  wire logic                     sck,
  input  wire logic                     cs_n,
  input  wire logic                     si,
  input  wire logic                     hold_n,
  input  wire logic                     wp_n,
  output logic                          so,
  output logic                          so_oe_n,
  // Save busy pin, open drain
  output logic                          hardware_save_busy_pin_out,
  output logic                          hardware_save_busy_pin_oe_n,
  // Status and nonvolatile engine requests
  output nvsram_spi_pkg::status_t       status,
  output logic                          autosave_enabled,
  output logic                          save_start,
  output logic                          restore_start
);
  import nvsram_spi_pkg::*;

  // ---- Link domain (sck) ----
  logic [4:0]         cnt;
  logic [2:0]         bitpos;
  logic [4:0]         next_cnt;
  logic [2:0]         next_bitpos;
  logic [7:0]         sh;
  logic [7:0]         next_sh;
  logic [15:0]        addr;
  logic [15:0]        next_addr;
  logic [7:0]         rd_byte;
  logic [7:0]         next_rd_byte;
  link_report_t       rpt;
  link_report_t       next_rpt;
  logic               mem_we;
  logic [7:0]         wdata;
  logic [7:0]         mem [0:(1 << ADDR_W) - 1];
  status_t            st_meta;
  status_t            st_link;
  logic               next_so;
  logic [7:0]         op_in;

  // Status copy for the link side; apart from the busy bit it only changes between frames.
  always_ff @(posedge sck) begin
    st_meta <= status;
    st_link <= st_meta;
  end

  // Frame position; cs_n high clears it so each frame restarts the parser.
  always_comb begin
    next_cnt    = cnt;
    next_bitpos = bitpos;
    if (hold_n) begin
      next_cnt    = (cnt == DATA_PHASE) ? cnt : cnt + 5'd1;
      next_bitpos = bitpos + 3'd1;
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt    <= 5'd0;
      bitpos <= 3'd0;
    end else begin
      cnt    <= next_cnt;
      bitpos <= next_bitpos;
    end
  end

  // Command decode, address, data path and array write.
  always_comb begin
    next_sh      = sh;
    next_addr    = addr;
    next_rd_byte = rd_byte;
    next_rpt     = rpt;
    mem_we       = 1'b0;
    op_in        = {sh[6:0], si};
    wdata        = {sh[6:0], si};
    if (hold_n) begin
      next_sh = {sh[6:0], si};
      if (cnt == 5'd0) begin
        next_rpt.mode   = MODE_IDLE;
        next_rpt.st_got = 1'b0;
      end
      if (cnt == OPCODE_LAST) begin
        next_rpt.op = op_in;
        if (op_in == OP_READ && !st_link.busy) begin
          next_rpt.mode = MODE_READ;
        end else if (op_in == OP_WRITE && st_link.write_latch && !st_link.busy) begin
          next_rpt.mode = MODE_WRITE;
        end else if (op_in == OP_STATUS_READ) begin
          next_rpt.mode = MODE_STATUS_RD;
          next_rd_byte  = st_link;
        end else if (op_in == OP_STATUS_WRITE) begin
          next_rpt.mode = MODE_STATUS_WR;
        end else begin
          next_rpt.mode = MODE_OTHER;
        end
      end
      if (rpt.mode == MODE_STATUS_WR && cnt == STATUS_LAST) begin
        next_rpt.st_byte = wdata;
        next_rpt.st_got  = 1'b1;
      end
      // Address is shifted in top bit first.
      if ((rpt.mode == MODE_READ || rpt.mode == MODE_WRITE) && cnt > OPCODE_LAST
          && cnt <= ADDR_LAST) begin
        next_addr = {addr[14:0], si};
      end
      if (rpt.mode == MODE_READ && cnt == ADDR_LAST) begin
        next_rd_byte = mem[{addr[14:0], si}];
      end
      // Byte boundaries in the data phase.
      if (cnt == DATA_PHASE && bitpos == BYTE_LAST) begin
        if (rpt.mode == MODE_WRITE) begin
          mem_we    = !in_protected(addr, {st_link.block_protect_high_bit,
                                           st_link.block_protect_low_bit});
          next_addr = addr + 16'd1;
        end else if (rpt.mode == MODE_READ) begin
          next_addr    = addr + 16'd1;
          next_rd_byte = mem[addr + 16'd1];
        end
      end
      if (rpt.mode == MODE_STATUS_RD && cnt > OPCODE_LAST && bitpos == BYTE_LAST) begin
        next_rd_byte = st_link;
      end
    end
  end

  always_ff @(posedge sck) begin
    sh      <= next_sh;
    addr    <= next_addr;
    rd_byte <= next_rd_byte;
    rpt     <= next_rpt;
    if (mem_we) begin
      mem[addr] <= wdata;
    end
  end

  // Output bit changes on the falling edge, top bit first.
  always_comb begin
    next_so = so;
    if (hold_n) begin
      next_so = rd_byte[~bitpos];
    end
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so <= 1'b0;
    end else begin
      so <= next_so;
    end
  end

  // Drive only for read data, and float while paused.
  // The mode left from the last frame must not drive before a new opcode is in.
  assign so_oe_n = !(!cs_n && hold_n && ((rpt.mode == MODE_STATUS_RD && cnt > OPCODE_LAST) ||
                   (rpt.mode == MODE_READ && cnt == DATA_PHASE)));

  // ---- System domain (clk) ----
  logic               cs_meta;
  logic               cs_sync;
  logic               cs_last;
  logic               wp_meta;
  logic               wp_sync;
  logic               wp_start;
  logic               next_wp_start;
  logic               cs_rise;
  logic               cs_fall;
  status_t            st;
  status_t            next_st;
  job_t               job;
  job_t               next_job;
  logic [15:0]        timer;
  logic [15:0]        next_timer;
  logic               next_autosave;
  logic               next_save_start;
  logic               next_restore_start;
  logic               wp_blocks;
  logic               special;

  // Pin synchronisers for chip select and the protect pin.
  always_ff @(posedge clk) begin
    cs_meta <= cs_n;
    cs_sync <= cs_meta;
    cs_last <= cs_sync;
    wp_meta <= wp_n;
    wp_sync <= wp_meta;
  end

  assign cs_rise   = cs_sync && !cs_last;
  assign cs_fall   = !cs_sync && cs_last;
  assign wp_blocks = st.pin_protect_enable_bit && !wp_start;
  assign special   = rpt.op == OP_SAVE || rpt.op == OP_RESTORE ||
                     rpt.op == OP_AUTOSAVE_ON || rpt.op == OP_AUTOSAVE_OFF;

  // Latch, status, autosave and busy job; the report is read once the frame has ended.
  always_comb begin
    next_st            = st;
    next_wp_start      = wp_start;
    next_job           = job;
    next_timer         = timer;
    next_autosave      = autosave_enabled;
    next_save_start    = 1'b0;
    next_restore_start = 1'b0;
    if (cs_fall) begin
      next_wp_start = wp_sync;
    end
    if (timer != TIMER_IDLE) begin
      next_timer = timer - 16'd1;
      if (timer == 16'd1) begin
        next_job = JOB_NONE;
      end
    end
    if (cs_rise) begin
      case (rpt.mode)
        MODE_WRITE: begin
          next_st.write_latch = 1'b0;
        end
        MODE_STATUS_WR: begin
          if (rpt.st_got && st.write_latch) begin
            if (!wp_blocks) begin
              next_st.pin_protect_enable_bit = rpt.st_byte[7];
              next_st.spare                  = rpt.st_byte[6:4];
              next_st.block_protect_high_bit = rpt.st_byte[3];
              next_st.block_protect_low_bit  = rpt.st_byte[2];
            end
            next_st.write_latch = 1'b0;
          end
        end
        MODE_OTHER: begin
          if (rpt.op == OP_SET_WRITE_LATCH) begin
            next_st.write_latch = 1'b1;
          end else if (rpt.op == OP_CLR_WRITE_LATCH) begin
            next_st.write_latch = 1'b0;
          end else if (special && st.write_latch && job == JOB_NONE) begin
            next_st.write_latch = 1'b0;
            if (rpt.op == OP_SAVE) begin
              next_job        = JOB_SAVE;
              next_timer      = SAVE_CYCLES;
              next_save_start = 1'b1;
            end else if (rpt.op == OP_RESTORE) begin
              next_job           = JOB_RESTORE;
              next_timer         = RESTORE_CYCLES;
              next_restore_start = 1'b1;
            end else begin
              next_job   = JOB_SEQ;
              next_timer = SEQ_CYCLES;
              if (HAS_AUTOSAVE) begin
                next_autosave = (rpt.op == OP_AUTOSAVE_ON);
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
    next_st.busy = (next_job != JOB_NONE);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st                          <= STATUS_RESET;
      wp_start                    <= 1'b1;
      job                         <= JOB_NONE;
      timer                       <= TIMER_IDLE;
      autosave_enabled            <= HAS_AUTOSAVE;
      save_start                  <= 1'b0;
      restore_start               <= 1'b0;
      hardware_save_busy_pin_oe_n <= 1'b1;
    end else begin
      st                          <= next_st;
      wp_start                    <= next_wp_start;
      job                         <= next_job;
      timer                       <= next_timer;
      autosave_enabled            <= next_autosave;
      save_start                  <= next_save_start;
      restore_start               <= next_restore_start;
      hardware_save_busy_pin_oe_n <= (next_job != JOB_SAVE);
    end
  end

  assign status                     = st;
  assign hardware_save_busy_pin_out = 1'b0;

  // Checks on the system side.
  wpin_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    cs_rise && rpt.mode == MODE_STATUS_WR && rpt.st_got && st.write_latch && wp_blocks
    |=> $stable({st.pin_protect_enable_bit, st.block_protect_high_bit,
                 st.block_protect_low_bit}))
    else $error("status written while protect pin blocks it");
  pin_protect_enable_bit_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    cs_rise && rpt.mode == MODE_STATUS_WR && rpt.st_got && st.write_latch
    && !st.pin_protect_enable_bit
    |=> {st.block_protect_high_bit, st.block_protect_low_bit} == $past(rpt.st_byte[3:2]))
    else $error("status write lost with pin enable clear");
  write_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    cs_rise && rpt.mode == MODE_WRITE |=> !st.write_latch)
    else $error("write latch survived a write");
  special_go_a: assert property (@(posedge clk) disable iff (sys_rst)
    cs_rise && rpt.mode == MODE_OTHER && special && st.write_latch && job == JOB_NONE
    |=> !st.write_latch && st.busy)
    else $error("special command not started or latch kept");
  save_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    job == JOB_SAVE |-> st.busy && !hardware_save_busy_pin_oe_n)
    else $error("save running without busy indication");
  seq_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(job == JOB_SEQ) |-> st.busy [*8])
    else $error("autosave command busy too short");
  busy_timer_a: assert property (@(posedge clk) disable iff (sys_rst)
    st.busy |-> timer != TIMER_IDLE && timer <= SAVE_CYCLES)
    else $error("busy flag without running timer");

  // Checks on the link side.
  wrap_read_a: assert property (@(posedge sck) disable iff (cs_n)
    rpt.mode == MODE_READ && cnt == DATA_PHASE && bitpos == BYTE_LAST && hold_n
    && addr == 16'hffff |=> addr == 16'h0000)
    else $error("read burst did not wrap to zero");
  hold_keep_a: assert property (@(posedge sck) disable iff (cs_n)
    !hold_n |=> $stable(cnt) && $stable(addr) && $stable(sh))
    else $error("state moved while paused");
  protect_a: assert property (@(posedge sck) disable iff (cs_n)
    mem_we |-> !(st_link.block_protect_high_bit && (st_link.block_protect_low_bit || addr[15]))
    && !(st_link.block_protect_low_bit && addr[15:14] == 2'b11))
    else $error("write into protected block");
  busy_reject_a: assert property (@(posedge sck) disable iff (cs_n)
    cnt == OPCODE_LAST && hold_n && st_link.busy |=> rpt.mode != MODE_READ
    && rpt.mode != MODE_WRITE)
    else $error("memory command accepted while busy");

  wrap_c: cover property (@(posedge sck) disable iff (cs_n)
    rpt.mode == MODE_READ && addr == 16'hffff ##1 addr == 16'h0000);
  store_c: cover property (@(posedge sck) disable iff (cs_n) mem_we);
  save_c: cover property (@(posedge clk) disable iff (sys_rst) save_start);
  hold_c: cover property (@(posedge sck) disable iff (cs_n) !hold_n && cnt == DATA_PHASE);
endmodule
`default_nettype wire

// file: spi_host_model.sv
// Purpose: Serial host that frames commands for the nonvolatile SRAM engine.
// Assumes: Mode 0 or 3 with a 30 ns serial clock that runs only inside frames.
// Notes:   The input line is inverted after release so a stale bit never looks valid.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Serial bus
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so,
  input  wire logic so_oe_n
);
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:7];
  logic       drove;
  logic       hold_oe;
  int         hold_at = -1;
  logic       cpol    = 1'b0;

  // Bus idles deselected with the clock parked low.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // Pauses with the clock low, toggles clock and input, then resumes with the clock low.
  task automatic pause();
    #5 hold_n = 1'b0;
    repeat (2) begin
      #15 sck = 1'b1;
      si = ~si;
      hold_oe = hold_oe & so_oe_n;
      #15 sck = 1'b0;
    end
    #5 hold_n = 1'b1;
  endtask

  // Sends n bytes top bit first and captures the output line on rising edges.
  task automatic frame(input int n);
    drove = 1'b0;
    hold_oe = 1'b1;
    sck = cpol;
    #7.3 cs_n = 1'b0;
    if (cpol) #15 sck = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        si = tx[i][b];
        #15 sck = 1'b1;
        rx[i][b] = so_oe_n ? 1'bx : so;
        drove = drove | ~so_oe_n;
        #15 sck = cpol && i == n - 1 && b == 0; // Mode 3 parks high after the last bit.
        if (i == hold_at && b == 4) pause();
      end
    end
    #15 cs_n = 1'b1;
    si = ~si;
    #12;
  endtask
endmodule
`default_nettype wire

// file: spi_nv_sram_access_protect_tb.sv
// Purpose: Self-checking bench for the serial nonvolatile SRAM engine.
// Assumes: Short busy counts so a save outlasts one read opcode.
// Notes:   Memory is read back only where this bench wrote it first.
`timescale 1ns/1ps
`default_nettype none
module spi_nv_sram_access_protect_tb;
  import nvsram_spi_pkg::*;
  localparam logic [7:0] SPECIAL [0:3] = '{OP_SAVE, OP_RESTORE, OP_AUTOSAVE_OFF, OP_AUTOSAVE_ON};
  localparam logic       AUTO_AFTER [0:3] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic       clk;
  logic       sys_rst;
  logic       wp_n;
  wire logic  sck;
  wire logic  cs_n;
  wire logic  si;
  wire logic  hold_n;
  logic       so;
  logic       so_oe_n;
  logic       busy_out;
  logic       busy_oe_n;
  logic       busy_wire;
  status_t    status;
  logic       autosave_enabled;
  logic       save_start;
  logic       restore_start;
  logic [7:0] wd [0:3];
  logic [7:0] ex [0:3];
  int         mismatches;
  int         checked;
  int         saves    = 0;
  int         restores = 0;

  nvsram_spi_engine #(.SAVE_CYCLES(16'd400)) nvsram_spi_engine_i (.clk(clk),
    .sys_rst(sys_rst), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n),
    .hardware_save_busy_pin_out(busy_out), .hardware_save_busy_pin_oe_n(busy_oe_n),
    .status(status), .autosave_enabled(autosave_enabled), .save_start(save_start),
    .restore_start(restore_start));
  spi_host_model host_i (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
    .so_oe_n(so_oe_n));

  // Open-drain busy pin with a pull-up.
  assign busy_wire = busy_oe_n ? 1'b1 : busy_out;
  // System clock.
  always #2 clk = ~clk;
  // Counts the start pulses of the nonvolatile engine.
  always @(negedge clk) begin
    if (save_start === 1'b1) saves <= saves + 1;
    if (restore_start === 1'b1) restores <= restores + 1;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d, checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Waits a bounded time for the busy bit to reach a level.
  task automatic wait_busy(input logic v, input int lim);
    int k;
    k = 0;
    while (status.busy !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (k == lim) begin
      mismatches++;
      $display("unexpected busy wait: expected %h, seen %h", v, status.busy);
      summarize();
    end
  endtask

  // One frame, then a deselect gap longer than eight system cycles.
  task automatic cmd(input logic [7:0] op, input int n);
    host_i.tx[0] = op;
    host_i.frame(n);
    repeat (8) @(negedge clk);
  endtask

  task automatic mem(input logic [7:0] op, input logic [15:0] a, input int n);
    host_i.tx[1] = a[15:8];
    host_i.tx[2] = a[7:0];
    for (int i = 0; i < n; i++) host_i.tx[3 + i] = (op == OP_READ) ? 8'h5a : wd[i];
    cmd(op, 3 + n);
  endtask

  task automatic wr(input logic [15:0] a, input int n);
    cmd(OP_SET_WRITE_LATCH, 1);
    mem(OP_WRITE, a, n);
  endtask

  // Reads n bytes with junk on the input line and compares them.
  task automatic rd(input logic [15:0] a, input int n);
    mem(OP_READ, a, n);
    for (int i = 0; i < n; i++) check("read data", host_i.rx[3 + i], ex[i]);
  endtask

  task automatic status_write_cmd(input logic [7:0] v);
    cmd(OP_SET_WRITE_LATCH, 1);
    host_i.tx[1] = v;
    cmd(OP_STATUS_WRITE, 2);
  endtask

  // Cuts a hang short.
  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    wp_n = 1'b1;
    mismatches = 0;
    checked = 0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    check("status reset", status, STATUS_RESET);
    check("autosave default", autosave_enabled, 1'b1);
    check("busy pin idle", busy_wire, 1'b1);
    cmd(OP_SET_WRITE_LATCH, 1);
    check("latch set", status.write_latch, 1'b1);
    wd = '{8'h11, 8'h22, 8'h33, 8'h44};
    mem(OP_WRITE, 16'hfffe, 4);
    check("latch after write", status.write_latch, 1'b0);
    cmd(OP_SET_WRITE_LATCH, 1);
    cmd(OP_CLR_WRITE_LATCH, 1);
    check("latch cleared", status.write_latch, 1'b0);
    wd[0] = 8'h99;
    mem(OP_WRITE, 16'hfffe, 1);
    host_i.hold_at = 4;
    ex = '{8'h11, 8'h22, 8'h33, 8'h44};
    rd(16'hfffe, 4);
    host_i.hold_at = -1;
    check("output during pause", host_i.hold_oe, 1'b1);
    status_write_cmd(8'h80);
    check("status", status, 8'h80);
    wp_n = 1'b0;
    status_write_cmd(8'h04);
    check("status pin blocked", status, 8'h80);
    wp_n = 1'b1;
    fork
      status_write_cmd(8'h84);
      begin
        #420 @(negedge clk) wp_n = 1'b0;
      end
    join
    check("status pin fell late", status, 8'h84);
    wp_n = 1'b1;
    status_write_cmd(8'h00);
    wp_n = 1'b0;
    status_write_cmd(8'h04);
    check("status pin ignored", status, 8'h04);
    wd[0] = 8'h77;
    wr(16'hfffe, 1);
    wd = '{8'haa, 8'hbb, 8'hcc, 8'h00};
    wr(16'hffff, 3);
    ex = '{8'h11, 8'h22, 8'hbb, 8'hcc};
    rd(16'hfffe, 4);
    status_write_cmd(8'h0c);
    wd[0] = 8'hee;
    wr(16'h0000, 1);
    ex[0] = 8'hbb;
    rd(16'h0000, 1);
    status_write_cmd(8'h08);
    wd[0] = 8'h12;
    wr(16'h7fff, 1);
    ex[0] = 8'h12;
    rd(16'h7fff, 1);
    host_i.cpol = 1'b1;
    wd[0] = 8'h34;
    wr(16'h1234, 1);
    ex[0] = 8'h34;
    rd(16'h1234, 1);
    host_i.cpol = 1'b0;
    for (int i = 0; i < 4; i++) begin
      cmd(OP_SET_WRITE_LATCH, 1);
      host_i.tx[0] = SPECIAL[i];
      host_i.frame(1);
      wait_busy(1'b1, 20);
      check("latch after special", status.write_latch, 1'b0);
      if (i == 0) begin
        @(negedge clk);
        check("busy pin", busy_wire, 1'b0);
        cmd(OP_STATUS_READ, 2);
        check("status read", host_i.rx[1], 8'h09);
        mem(OP_READ, 16'h0000, 1);
        check("read while busy", host_i.drove, 1'b0);
      end
      wait_busy(1'b0, 400);
      repeat (8) @(negedge clk);
      check("autosave", autosave_enabled, AUTO_AFTER[i]);
    end
    check("saves", 16'(saves), 16'd1);
    check("restores", 16'(restores), 16'd1);
    host_i.tx[0] = OP_SAVE;
    host_i.frame(1);
    repeat (20) @(negedge clk);
    check("save without latch", status.busy, 1'b0);
    check("saves", 16'(saves), 16'd1);
    summarize();
  end
endmodule
`default_nettype wire
